// ---- verilog/flash_ctrl_pkg.sv ----
/*
 * constants, types and register map of the flash program/erase control
 * block. assumes a single system clock and a byte-wide register port.
 */
package flash_ctrl_pkg;

  // ****************************************************************
  // register map (byte offsets on the register port)
  // ****************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h4C; // flash_control
  localparam logic [7:0] OFF_STATUS = 8'h4E; // flash_status
  localparam logic [7:0] OFF_PRESCALER = 8'h50; // flash_prescaler
  localparam logic [7:0] OFF_START = 8'h52; // start_delay_reload
  localparam logic [7:0] OFF_TRANSITION = 8'h54; // transition_delay_reload

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_LOW_POWER_READ = 0;
  localparam int CTL_CPU_WRITE_INHIBIT = 1;
  localparam int CTL_VERIFY_DISABLE = 3;
  localparam int CTL_IRQ_ENABLE = 4;
  localparam int CTL_PROGRAM_ENABLE = 5;
  localparam int CTL_PAGE_ERASE = 6;
  localparam int CTL_MODULE_ERASE = 7;
  localparam int STS_ERASE_ERROR = 0;
  localparam int STS_PROGRAM_ERROR = 1;
  localparam int STS_BUSY = 2;
  localparam int STS_BUFFER_FULL = 3;
  localparam int STS_DATA_LOSS = 4;
  localparam int PAGE_LSB = 10; // 1024-byte pages

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'hFB; // bit 2 reserved
  localparam logic [7:0] PRESCALER_RESET = 8'h04;
  localparam logic [7:0] PRESCALER_MASK = 8'h1F; // 5-bit divisor
  localparam logic [7:0] START_RESET = 8'h18;
  localparam logic [7:0] TRANSITION_RESET = 8'h30;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_CLK_MHZ = 50;
  localparam int LOW_POWER_MAX_MHZ = 25;
  localparam logic [7:0] PULSE_TICKS = 8'h0F; // pulse length minus one

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_PAGE_ERASE = 2'h1,
    OP_BLOCK_ERASE = 2'h2,
    OP_PAIR_ERASE = 2'h3 // information block plus its main block
  } op_kind_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_TRAN = 5'b00100,
    ST_PULSE = 5'b01000,
    ST_VERIFY = 5'b10000
  } seq_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] data;
    logic info_block;
  } flash_write_s;

  typedef struct packed {
    op_kind_e kind;
    logic [17:0] addr;
    logic [15:0] data;
    logic info_block;
  } flash_op_s;

endpackage : flash_ctrl_pkg

// ---- verilog/phase_timer.sv ----
/*
 * phase delay counter: counts a loaded value plus one prescaler ticks.
 * assumes tick_i is a one-cycle pulse in the same clock domain.
 */
module phase_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [7:0] count_i,
  output logic done_o
);

  // ****************************************************************
  // counter
  // ****************************************************************
  logic [7:0] remaining; // ticks left minus one
  logic running; // phase in progress

  // a load always restarts, so a new phase never inherits an old count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remaining <= 8'h00;
      running <= 1'b0;
      done_o <= 1'b0;
    end else if (en_i) begin
      done_o <= 1'b0;
      if (load_i) begin
        remaining <= count_i;
        running <= 1'b1;
      end else if (running && tick_i) begin
        // zero left: this tick is the last one of the phase
        if (remaining == 8'h00) begin
          running <= 1'b0;
          done_o <= 1'b1;
        end else begin
          remaining <= remaining - 8'h01;
        end
      end
    end
  end

endmodule : phase_timer

// ---- verilog/flash_program_erase_control.sv ----
/*
 * flash program/erase control: control, status and timing registers,
 * one-word write buffer and the program/erase sequencer.
 * assumes the cpu write port and register port are synchronous to clk_i
 * and the array answers verify and erase results in the same domain.
 */
module flash_program_erase_control (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i, // freezes all state while low
  input wire flash_ctrl_pkg::reg_req_s reg_req_i, // register port
  output logic [7:0] reg_rdata_o, // read data, one cycle after rd
  input wire logic flash_wr_i, // cpu write to flash
  input wire flash_ctrl_pkg::flash_write_s flash_wr_data_i,
  output logic cpu_stall_o, // hold the cpu
  output logic op_start_o, // operation handed to the array
  output flash_ctrl_pkg::flash_op_s op_o, // operation being run
  output logic op_pulse_o, // program/erase pulse to the array
  output logic verify_req_o, // start of automatic verify
  input wire logic verify_done_i,
  input wire logic verify_fail_i,
  input wire logic erase_fail_i, // sampled at end of erase pulse
  output logic low_power_read_o, // array reads in first half-period
  input wire logic data_flash_irq_i, // request of the data flash side
  output logic flash_irq_o // shared interrupt channel
);
  import flash_ctrl_pkg::*;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // returns {valid, kind}; more than one mode bit set is no mode at all
  function automatic logic [2:0] op_of(input logic [7:0] ctl,
                                       input logic info);
    logic [2:0] modes;
    modes = {ctl[CTL_MODULE_ERASE], ctl[CTL_PAGE_ERASE],
             ctl[CTL_PROGRAM_ENABLE]};
    case (modes)
      3'b001: op_of = {1'b1, OP_PROGRAM};
      3'b010: op_of = {!info, OP_PAGE_ERASE};
      3'b100: op_of = {1'b1, info ? OP_PAIR_ERASE : OP_BLOCK_ERASE};
      default: op_of = 3'b000;
    endcase
  endfunction : op_of

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0] control; // flash_control
  logic [7:0] prescaler; // flash_prescaler
  logic [7:0] start_reload; // start_delay_reload
  logic [7:0] transition_reload; // transition_delay_reload
  logic erase_error; // sticky
  logic program_error; // sticky
  logic data_loss_error; // sticky
  logic busy; // flash_busy
  logic buf_full; // write_buffer_full
  flash_write_s buf_word; // staged cpu write
  op_kind_e buf_kind; // operation staged with it
  seq_state_e state; // sequencer state
  logic [4:0] psc_count; // prescaler counter
  logic tick; // prescaler output clock
  logic timer_load; // starts a phase
  logic [7:0] timer_count; // phase length minus one
  logic timer_done; // phase ended

  // ****************************************************************
  // request qualification
  // ****************************************************************
  logic [2:0] req_op; // decoded mode for this write
  logic req_ok; // writable and a valid mode
  logic req_erase; // decoded request is an erase
  logic stall; // erase request while busy
  logic accept; // write goes into the buffer
  logic overrun; // write arrives with the buffer full
  logic take; // sequencer empties the buffer
  logic reg_wr_status; // status write strobe
  logic erase_err_set; // erase failed this cycle
  logic program_err_set; // verify failed this cycle

  always_comb begin
    req_op = op_of(control, flash_wr_data_i.info_block);
    req_ok = flash_wr_i && !control[CTL_CPU_WRITE_INHIBIT]
             && req_op[2];
    req_erase = req_op[1:0] != OP_PROGRAM;
    stall = req_ok && req_erase && busy;
    accept = req_ok && !buf_full && !stall;
    overrun = req_ok && buf_full && !stall;
    take = (state == ST_IDLE) && buf_full;
    reg_wr_status = reg_req_i.wr && (reg_req_i.addr == OFF_STATUS);
    erase_err_set = (state == ST_PULSE) && timer_done
                    && (op_o.kind != OP_PROGRAM) && erase_fail_i;
    program_err_set = (state == ST_VERIFY) && verify_done_i
                      && verify_fail_i;
  end

  // ****************************************************************
  // control and timing registers
  // ****************************************************************
  // no interlock against writes while busy: software must not do that
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control <= CONTROL_RESET;
      prescaler <= PRESCALER_RESET;
      start_reload <= START_RESET;
      transition_reload <= TRANSITION_RESET;
    end else if (clk_en_i && reg_req_i.wr) begin
      case (reg_req_i.addr)
        OFF_CONTROL: control <= reg_req_i.wdata & CONTROL_MASK;
        OFF_PRESCALER: prescaler <= reg_req_i.wdata & PRESCALER_MASK;
        OFF_START: start_reload <= reg_req_i.wdata;
        OFF_TRANSITION: transition_reload <= reg_req_i.wdata;
        default: ; // other offsets hold no storage here
      endcase
    end
  end

  // ****************************************************************
  // sticky error flags
  // ****************************************************************
  // a failure landing in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      erase_error <= 1'b0;
      program_error <= 1'b0;
      data_loss_error <= 1'b0;
    end else if (clk_en_i) begin
      if (erase_err_set) begin
        erase_error <= 1'b1;
      end else if (reg_wr_status && reg_req_i.wdata[STS_ERASE_ERROR]) begin
        erase_error <= 1'b0;
      end
      if (program_err_set) begin
        program_error <= 1'b1;
      end else if (reg_wr_status
                   && reg_req_i.wdata[STS_PROGRAM_ERROR]) begin
        program_error <= 1'b0;
      end
      if (overrun) begin
        data_loss_error <= 1'b1;
      end else if (reg_wr_status && reg_req_i.wdata[STS_DATA_LOSS]) begin
        data_loss_error <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // read data is registered; unmapped offsets and reserved bits read 0
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i && reg_req_i.rd) begin
      case (reg_req_i.addr)
        OFF_CONTROL: reg_rdata_o <= control;
        OFF_STATUS: reg_rdata_o <= {3'h0, data_loss_error, buf_full,
                                    busy, program_error, erase_error};
        OFF_PRESCALER: reg_rdata_o <= prescaler;
        OFF_START: reg_rdata_o <= start_reload;
        OFF_TRANSITION: reg_rdata_o <= transition_reload;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // write buffer
  // ****************************************************************
  // one word deep: a program write may wait here while the previous
  // operation runs, which lets software stream words back to back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_full <= 1'b0;
      buf_word <= '0;
      buf_kind <= OP_PROGRAM;
    end else if (clk_en_i) begin
      if (accept) begin
        buf_full <= 1'b1;
        buf_word <= flash_wr_data_i;
        buf_kind <= op_kind_e'(req_op[1:0]);
      end else if (take) begin
        buf_full <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // restarted while idle so every sequence sees whole tick periods
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psc_count <= 5'h00;
      tick <= 1'b0;
    end else if (clk_en_i) begin
      if (state == ST_IDLE) begin
        psc_count <= 5'h00;
        tick <= 1'b0;
      end else if (psc_count == prescaler[4:0]) begin
        psc_count <= 5'h00;
        tick <= 1'b1;
      end else begin
        psc_count <= psc_count + 5'h01;
        tick <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // phase timer
  // ****************************************************************
  always_comb begin
    timer_load = 1'b0;
    timer_count = start_reload;
    case (state)
      ST_IDLE: begin
        timer_load = take;
        timer_count = start_reload;
      end
      ST_START: begin
        timer_load = timer_done;
        timer_count = transition_reload;
      end
      ST_TRAN: begin
        timer_load = timer_done;
        timer_count = PULSE_TICKS;
      end
      default: begin
        timer_load = 1'b0;
        timer_count = start_reload;
      end
    endcase
  end

  phase_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(clk_en_i),
    .tick_i(tick),
    .load_i(timer_load),
    .count_i(timer_count),
    .done_o(timer_done)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // a page erase aligns the staged address to its 1024-byte page; other modes pass it unchanged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      op_o <= '0;
      op_start_o <= 1'b0;
      op_pulse_o <= 1'b0;
      verify_req_o <= 1'b0;
    end else if (clk_en_i) begin
      op_start_o <= 1'b0;
      verify_req_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            state <= ST_START;
            busy <= 1'b1;
            op_start_o <= 1'b1;
            op_o.kind <= buf_kind;
            op_o.data <= buf_word.data;
            op_o.info_block <= buf_word.info_block;
            op_o.addr <= buf_word.addr;
            if (buf_kind == OP_PAGE_ERASE) begin
              op_o.addr <= {buf_word.addr[17:PAGE_LSB],
                            {PAGE_LSB{1'b0}}};
            end
          end
        end
        ST_START: begin
          if (timer_done) begin
            state <= ST_TRAN;
          end
        end
        ST_TRAN: begin
          if (timer_done) begin
            state <= ST_PULSE;
            op_pulse_o <= 1'b1;
          end
        end
        ST_PULSE: begin
          if (timer_done) begin
            op_pulse_o <= 1'b0;
            if (op_o.kind == OP_PROGRAM
                && !control[CTL_VERIFY_DISABLE]) begin
              state <= ST_VERIFY;
              verify_req_o <= 1'b1;
            end else begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end
          end
        end
        ST_VERIFY: begin
          if (verify_done_i) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
          op_pulse_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // cpu stall, interrupt and read mode
  // ****************************************************************
  // the low-power flag only informs the array; at 50 MHz it is outside
  // its rated range, so software should leave it clear here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_stall_o <= 1'b0;
      flash_irq_o <= 1'b0;
      low_power_read_o <= 1'b0;
    end else if (clk_en_i) begin
      cpu_stall_o <= stall;
      flash_irq_o <= (take && control[CTL_IRQ_ENABLE])
                     || data_flash_irq_i;
      low_power_read_o <= control[CTL_LOW_POWER_READ];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_seq_start;
    clk_en_i && state == ST_IDLE && buf_full;
  endsequence

  sequence s_erase_busy;
    clk_en_i && flash_wr_i && busy && !control[CTL_CPU_WRITE_INHIBIT]
    && req_op[2] && req_op[1:0] != OP_PROGRAM;
  endsequence

  inhibit_blocks_a: assert property (
    clk_en_i && flash_wr_i && control[CTL_CPU_WRITE_INHIBIT] && !buf_full
    |=> !buf_full)
    else $error("write accepted while cpu writes inhibited");

  program_gate_a: assert property (
    clk_en_i && flash_wr_i && !buf_full && control[7:5] == 3'b000
    |=> !buf_full)
    else $error("write accepted with no mode enabled");

  page_info_a: assert property (
    clk_en_i && flash_wr_i && !buf_full && control[7:5] == 3'b010
    && flash_wr_data_i.info_block |=> !buf_full)
    else $error("page erase of information block accepted");

  stall_busy_a: assert property (
    s_erase_busy |=> cpu_stall_o)
    else $error("erase request while busy did not stall");

  // the flag must still stand one cycle on, unless software cleared it
  loss_flag_a: assert property (
    clk_en_i && overrun |=> data_loss_error ##1 (data_loss_error
    || $past(reg_wr_status && reg_req_i.wdata[STS_DATA_LOSS])))
    else $error("overrun did not set data loss flag");

  erase_clear_a: assert property (
    clk_en_i && reg_wr_status && reg_req_i.wdata[STS_ERASE_ERROR]
    && !erase_err_set |=> !erase_error)
    else $error("erase error not cleared by write of one");

  seq_busy_a: assert property (
    s_seq_start |=> busy && state == ST_START && op_start_o)
    else $error("sequence did not start from a full buffer");

  irq_free_a: assert property (
    s_seq_start and control[CTL_IRQ_ENABLE] |=> flash_irq_o && !buf_full)
    else $error("no interrupt when buffer became free");

  tick_rate_a: assert property (
    clk_en_i && tick && prescaler[4:0] == 5'h01 && state != ST_IDLE
    ##1 clk_en_i && state != ST_IDLE |-> !tick ##1 tick)
    else $error("prescaler period wrong for divisor one");

endmodule : flash_program_erase_control

// ---- test/flash_array_model.sv ----
/* behavioural flash array: answers verify requests, reports erase faults.
   assumes the controller's clock and reset. */
module flash_array_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic verify_req_i,
  input wire logic op_pulse_i,
  input wire logic fail_verify_i, // make the next verify fail
  input wire logic fail_erase_i, // make erase pulses fail
  input wire logic slow_i, // answer verify late
  output logic verify_done_o,
  output logic verify_fail_o,
  output logic erase_fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt; // cycles left before the verify answer
  // fault shown for the whole pulse, so its last cycle sees it
  assign erase_fail_o = op_pulse_i & fail_erase_i;
  // verify answer after one or four cycles; fail line toggles when unused
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 3'h0;
      verify_done_o <= 1'b0;
      verify_fail_o <= 1'b0;
    end else if (verify_req_i) begin
      wait_cnt <= slow_i ? 3'h4 : 3'h1;
      verify_done_o <= 1'b0;
      verify_fail_o <= ~verify_fail_o;
    end else if (wait_cnt == 3'h1) begin
      wait_cnt <= 3'h0;
      verify_done_o <= 1'b1;
      verify_fail_o <= fail_verify_i;
    end else begin
      wait_cnt <= (wait_cnt != 3'h0) ? wait_cnt - 3'h1 : 3'h0;
      verify_done_o <= 1'b0;
      verify_fail_o <= ~verify_fail_o;
    end
  end
endmodule : flash_array_model

// ---- test/flash_program_erase_control_tb.sv ----
/* self-checking bench of the program/erase control block.
   assumes the array model beside it and 50 MHz clocking. */
module flash_program_erase_control_tb;
  import flash_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_n_i = 0, fwr = 0, dirq = 0, fv = 0, fe = 0, slow = 0;
  logic rd_taken = 0, irq_en = 0;
  logic stall, ostart, pulse, vreq, vdone, vfail, efail, lpr, irq;
  logic [7:0] rdata, s, t;
  reg_req_s rq = '0;
  flash_write_s fwd = '0;
  flash_op_s op, e;
  int fails = 0, comparisons = 0, vreqs = 0, hi = 0, sp = 0, lo = 0;
  logic [7:0] exp_rd[$]; // expected register reads
  flash_op_s exp_op[$]; // expected operations
  always #10 clk_i = ~clk_i;
  flash_program_erase_control i_flash_program_erase_control (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .reg_req_i(rq),
    .reg_rdata_o(rdata), .flash_wr_i(fwr), .flash_wr_data_i(fwd),
    .cpu_stall_o(stall), .op_start_o(ostart), .op_o(op),
    .op_pulse_o(pulse), .verify_req_o(vreq), .verify_done_i(vdone),
    .verify_fail_i(vfail), .erase_fail_i(efail), .low_power_read_o(lpr),
    .data_flash_irq_i(dirq), .flash_irq_o(irq));
  flash_array_model i_flash_array_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .verify_req_i(vreq),
    .op_pulse_i(pulse), .fail_verify_i(fv), .fail_erase_i(fe),
    .slow_i(slow), .verify_done_o(vdone), .verify_fail_o(vfail),
    .erase_fail_o(efail));
  task automatic chk(input logic [35:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  // ****************************************************
  // drivers: change just after the edge, hold for one edge
  // ****************************************************
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    #1;
    rq = '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    #1;
    rq = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, ex);
    exp_rd.push_back(ex);
    @(posedge clk_i);
    #1;
    rq = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    #1;
    rq = '0;
  endtask : rd
  task automatic fw(input logic [17:0] a, input logic ib,
                    input op_kind_e k, input bit go);
    @(posedge clk_i);
    #1;
    fwd = '{a, 16'($urandom), ib};
    fwr = 1'b1;
    if (go) exp_op.push_back('{k, (k == OP_PAGE_ERASE) ?
      {a[17:10], 10'h000} : a, fwd.data, ib});
    @(posedge clk_i);
    #1;
    fwr = 1'b0;
  endtask : fw
  // bounded wait for the pulse to end, then room for verify
  task automatic wait_done();
    int n;
    n = 0;
    while (!pulse && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    while (pulse && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      chk(0, 1, "operation timeout");
      end_sim();
    end
    repeat (12) @(posedge clk_i);
  endtask : wait_done
  task automatic tdone(input string m);
    $display("test %s done", m);
  endtask : tdone
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // watcher: takes the oldest note whenever a result appears
  always @(posedge clk_i) rd_taken <= rq.rd;
  always @(negedge clk_i) begin
    if (rd_taken) chk(rdata, exp_rd.pop_front(), "register read");
    sp++;
    if (ostart) begin
      sp = 0;
      if (exp_op.size() == 0) chk(0, 1, "unexpected operation");
      else begin
        e = exp_op.pop_front();
        chk({op.kind, op.addr, op.info_block},
            {e.kind, e.addr, e.info_block}, "operation");
        if (e.kind == OP_PROGRAM) chk(op.data, e.data, "program data");
        chk(irq, irq_en, "buffer free request");
      end
    end
    if (vreq) vreqs++;
    if (pulse) begin
      if (hi == 0) chk(sp >= lo - 2 && sp <= lo + 2, 1, "delays");
      hi++;
    end else if (hi != 0) begin
      chk(hi, 32, "pulse length");
      hi = 0;
    end
  end
  initial begin
    #1_000_000;
    fails++;
    end_sim();
  end
  initial begin
    s = 8'($urandom(32'hB0FDC3BA) % 4);
    t = 8'($urandom % 4);
    lo = (s + t + 2) * 2;
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    rd(OFF_CONTROL, 8'h00);
    rd(OFF_STATUS, 8'h00);
    rd(OFF_PRESCALER, 8'h04);
    rd(OFF_START, 8'h18);
    rd(OFF_TRANSITION, 8'h30);
    rd(8'h56, 8'h00);
    // timing set only while idle, divide by two
    wr(OFF_PRESCALER, 8'hE1);
    rd(OFF_PRESCALER, 8'h01);
    wr(OFF_START, s);
    wr(OFF_TRANSITION, t);
    rd(OFF_START, s);
    tdone("reset and timing");
    // one mode bit at a time, changed only while idle
    irq_en = 1'b1;
    fv = 1'b1;
    slow = 1'b1;
    wr(OFF_CONTROL, 8'h30);
    fw(18'($urandom), 1'b0, OP_PROGRAM, 1'b1);
    rd(OFF_STATUS, 8'h04);
    wait_done();
    chk(vreqs, 1, "verify count");
    rd(OFF_STATUS, 8'h02);
    wr(OFF_STATUS, 8'h00);
    rd(OFF_STATUS, 8'h02);
    wr(OFF_STATUS, 8'h02);
    rd(OFF_STATUS, 8'h00);
    tdone("program with failing verify");
    irq_en = 1'b0;
    fv = 1'b0;
    wr(OFF_CONTROL, 8'h28);
    fw(18'($urandom), 1'b0, OP_PROGRAM, 1'b1);
    repeat (3) @(posedge clk_i);
    fw(18'($urandom), 1'b0, OP_PROGRAM, 1'b1);
    fw(18'($urandom), 1'b0, OP_PROGRAM, 1'b0);
    rd(OFF_STATUS, 8'h1C);
    wait_done();
    wait_done();
    chk(vreqs, 1, "verify skipped");
    rd(OFF_STATUS, 8'h10);
    wr(OFF_STATUS, 8'h10);
    rd(OFF_STATUS, 8'h00);
    tdone("buffer overrun");
    fe = 1'b1;
    wr(OFF_CONTROL, 8'h40);
    fw(18'($urandom), 1'b0, OP_PAGE_ERASE, 1'b1);
    repeat (3) @(posedge clk_i);
    fw(18'($urandom), 1'b0, OP_PAGE_ERASE, 1'b0);
    chk(stall, 1, "stall on busy erase");
    wait_done();
    rd(OFF_STATUS, 8'h01);
    wr(OFF_STATUS, 8'h01);
    rd(OFF_STATUS, 8'h00);
    fe = 1'b0;
    fw(18'($urandom), 1'b1, OP_PAGE_ERASE, 1'b0);
    repeat (10) @(posedge clk_i);
    tdone("page erase");
    wr(OFF_CONTROL, 8'h80);
    fw(18'($urandom), 1'b0, OP_BLOCK_ERASE, 1'b1);
    wait_done();
    fw(18'($urandom), 1'b1, OP_PAIR_ERASE, 1'b1);
    wait_done();
    tdone("module erase");
    wr(OFF_CONTROL, 8'h22);
    fw(18'($urandom), 1'b0, OP_PROGRAM, 1'b0);
    wr(OFF_CONTROL, 8'h00);
    fw(18'($urandom), 1'b0, OP_PROGRAM, 1'b0);
    repeat (10) @(posedge clk_i);
    tdone("refused writes");
    // no array reads are made while busy
    wr(OFF_CONTROL, 8'h01);
    repeat (2) @(posedge clk_i);
    #1;
    chk(lpr, 1, "low power read");
    dirq = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq, 1, "shared request");
    dirq = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq, 0, "shared request off");
    tdone("flags");
    end_sim();
  end
endmodule : flash_program_erase_control_tb
